/* design/addon_nv_memory_access_control.sv */
// Add-on general control/status register with nv memory access port and flag resets.
// Notes on behaviour
// - Register decoded at add-on offset 3Ch
// - Power-up value depends on bus mastering mode
// - Software resets mailbox and FIFO flags
// - Codes 100/101 latch low/high address byte
// - Codes 110/111 begin memory write/read
// - Top bit reads busy during memory operation
// - Bits 23:16 form the nv port byte
// - Bit 27 pulses mailbox flag reset
// - Bit 26 pulses outbound FIFO flag reset
// - Bit 25 pulses inbound FIFO flag reset
`timescale 1ns/10ps
module addon_nv_memory_access_control #(
  parameter int ACCESS_CYCLES = nv_access_pkg::NV_ACCESS_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic addonMasterMode,
  input nv_access_pkg::reg_req_s regReq,
  input wire logic [nv_access_pkg::STAT_MSB:nv_access_pkg::STAT_LSB] statusIn,
  input wire logic [7:0] nvDataIn,
  output logic [31:0] regRdata,
  output logic regRdValid,
  output logic mailboxFlagReset,
  output logic outFifoFlagReset,
  output logic inFifoFlagReset,
  output logic transferCountEnable,
  output nv_access_pkg::nv_pins_s nvPins
);
  import nv_access_pkg::*;

  logic wrHit, rdHit, cmdLane, portLane, stepOk, startOp, done;
  logic [2:0] cmd;
  logic [7:0] portNew, rdByte;
  logic busy_q, busy_d;
  logic [1:0] op_q, op_d;
  logic [7:0] port_q, port_d, addrLo_q, addrLo_d, addrHi_q, addrHi_d;
  logic [7:0] stat_q, stat_d;
  logic tce_q, tce_d, mbx_q, mbx_d, outRst_q, outRst_d, inRst_q, inRst_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdValid_q, rdValid_d;

  // Decode of one register access; steps are refused while busy.
  assign wrHit = regReq.sel && regReq.wr && (regReq.addr == AGCS_OFFSET);
  assign rdHit = regReq.sel && regReq.rd && (regReq.addr == AGCS_OFFSET);
  assign cmdLane = regReq.be[LANE_CMD];
  assign portLane = regReq.be[LANE_PORT];
  assign cmd = regReq.wdata[CMD_MSB:CMD_LSB];
  assign stepOk = wrHit && cmdLane && regReq.wdata[BIT_GO] && !busy_q;
  assign startOp = stepOk && cmd[1];
  assign portNew = portLane ? regReq.wdata[PORT_MSB:PORT_LSB] : port_q;

  // Memory cycle engine for begin write and begin read steps.
  nv_byte_port #(.ACCESS_CYCLES(ACCESS_CYCLES)) engine (
    .mclk(mclk),
    .srst(srst),
    .start(startOp),
    .isRead(cmd == CMD_READ),
    .memAddr({addrHi_q, addrLo_q}),
    .memWdata(portNew),
    .nvDataIn(nvDataIn),
    .nvPins(nvPins),
    .done(done),
    .rdByte(rdByte)
  );

  // Access step sequencing: address latches, port byte and busy flag.
  always_comb
  begin
    busy_d = busy_q;
    op_d = op_q;
    port_d = port_q;
    addrLo_d = addrLo_q;
    addrHi_d = addrHi_q;
    if (done)
    begin
      busy_d = 1'b0;
      if (op_q == CMD_READ[1:0])
      begin
        port_d = rdByte;
      end
    end
    if (stepOk)
    begin
      op_d = cmd[1:0];
      port_d = portNew;
      if (cmd == CMD_LOAD_LO)
      begin
        addrLo_d = portNew;
      end
      if (cmd == CMD_LOAD_HI)
      begin
        addrHi_d = portNew;
      end
      if (startOp)
      begin
        busy_d = 1'b1;
      end
    end
  end

  // Control bits, one-cycle flag reset pulses and status sampling.
  always_comb
  begin
    tce_d = tce_q;
    mbx_d = 1'b0;
    outRst_d = 1'b0;
    inRst_d = 1'b0;
    stat_d = {statusIn, 1'b0};
    if (wrHit && cmdLane)
    begin
      tce_d = regReq.wdata[BIT_TCE];
      mbx_d = regReq.wdata[BIT_MBX_RST];
      outRst_d = regReq.wdata[BIT_OUT_RST];
      inRst_d = regReq.wdata[BIT_IN_RST];
    end
  end

  // Read data: write-only and reserved bits return zero.
  always_comb
  begin
    rdValid_d = rdHit;
    rdata_d = rdata_q;
    if (rdHit)
    begin
      rdata_d = '0;
      rdata_d[BIT_GO] = busy_q;
      rdata_d[CMD_LSB+1:CMD_LSB] = op_q;
      rdata_d[BIT_TCE] = tce_q;
      rdata_d[PORT_MSB:PORT_LSB] = port_q;
      rdata_d[STAT_MSB:0] = stat_q;
    end
  end

  // Register stage; power-up value follows the bus mastering mode.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      busy_q <= 1'b0;
      op_q <= 2'b00;
      port_q <= 8'h00;
      addrLo_q <= 8'h00;
      addrHi_q <= 8'h00;
      tce_q <= 1'b0;
      mbx_q <= 1'b0;
      outRst_q <= 1'b0;
      inRst_q <= 1'b0;
      stat_q <= addonMasterMode ? RESET_ADDON_MASTER[7:0] : RESET_PCI_MASTER[7:0];
      rdata_q <= 32'h00000000;
      rdValid_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      op_q <= op_d;
      port_q <= port_d;
      addrLo_q <= addrLo_d;
      addrHi_q <= addrHi_d;
      tce_q <= tce_d;
      mbx_q <= mbx_d;
      outRst_q <= outRst_d;
      inRst_q <= inRst_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
      rdValid_q <= rdValid_d;
    end
  end

  // Outputs come straight from the register stage.
  assign regRdata = rdata_q;
  assign regRdValid = rdValid_q;
  assign mailboxFlagReset = mbx_q;
  assign outFifoFlagReset = outRst_q;
  assign inFifoFlagReset = inRst_q;
  assign transferCountEnable = tce_q;

  // Checks of the register and access behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_read_offset: assert property (rdHit |=> regRdValid && regRdata[BIT_GO] == $past(busy_q))
    else $error("read of control register not answered");
  a_reset_value: assert property ($past(srst) |-> stat_q ==
    ($past(addonMasterMode) ? RESET_ADDON_MASTER[7:0] : RESET_PCI_MASTER[7:0]))
    else $error("power-up status wrong");
  a_lo_latch: assert property (stepOk && cmd == CMD_LOAD_LO && portLane
    |=> addrLo_q == $past(regReq.wdata[PORT_MSB:PORT_LSB]) && !busy_q)
    else $error("low address byte not latched");
  a_hi_latch: assert property (stepOk && cmd == CMD_LOAD_HI && portLane
    |=> addrHi_q == $past(regReq.wdata[PORT_MSB:PORT_LSB]))
    else $error("high address byte not latched");
  a_start_busy: assert property (startOp |=> busy_q && (!nvPins.weN || !nvPins.oeN))
    else $error("memory operation did not start");
  a_inactive_step: assert property (wrHit && cmdLane && !regReq.wdata[BIT_GO] && !done
    |=> busy_q == $past(busy_q) && addrLo_q == $past(addrLo_q))
    else $error("inactive write started a step");
  a_busy_bounded: assert property (startOp |-> ##[2:12] !busy_q)
    else $error("busy did not clear in time");
  a_done_ready: assert property (done |=> !busy_q)
    else $error("busy not cleared on done");
  a_read_byte: assert property (done && op_q == CMD_READ[1:0] |=> port_q == $past(rdByte))
    else $error("read byte not placed in port");
  a_mbx_pulse: assert property (wrHit && cmdLane && regReq.wdata[BIT_MBX_RST]
    |=> mailboxFlagReset ##1 (!mailboxFlagReset || $past(wrHit)))
    else $error("mailbox reset pulse wrong");
  a_out_pulse: assert property (wrHit && cmdLane && regReq.wdata[BIT_OUT_RST]
    |=> outFifoFlagReset)
    else $error("outbound flag reset missing");
  a_in_pulse: assert property (wrHit && cmdLane && regReq.wdata[BIT_IN_RST]
    |=> inFifoFlagReset)
    else $error("inbound flag reset missing");
  a_wo_zero: assert property (regRdValid |-> regRdata[BIT_MBX_RST:BIT_IN_RST] == 3'h0)
    else $error("write-only bits read nonzero");

  c_write_op: cover property (startOp && cmd == CMD_WRITE ##[1:12] done);
  c_read_op: cover property (startOp && cmd == CMD_READ ##[1:12] done);
  c_busy_refused: cover property (wrHit && cmdLane && regReq.wdata[BIT_GO] && busy_q);

endmodule : addon_nv_memory_access_control

/* design/nv_access_pkg.sv */
// Shared constants and carrier types for the add-on control/status block.
package nv_access_pkg;

  // Register placement within the add-on register space.
  localparam int REG_ADDR_W = 6;
  localparam logic [REG_ADDR_W-1:0] AGCS_OFFSET = 6'h3c;

  // Power-up contents for the two bus-mastering modes.
  localparam logic [31:0] RESET_PCI_MASTER = 32'h000000f4;
  localparam logic [31:0] RESET_ADDON_MASTER = 32'h00000034;

  // Field positions inside the control/status word.
  localparam int BIT_GO = 31;
  localparam int CMD_MSB = 31;
  localparam int CMD_LSB = 29;
  localparam int BIT_TCE = 28;
  localparam int BIT_MBX_RST = 27;
  localparam int BIT_OUT_RST = 26;
  localparam int BIT_IN_RST = 25;
  localparam int PORT_MSB = 23;
  localparam int PORT_LSB = 16;
  localparam int STAT_MSB = 7;
  localparam int STAT_LSB = 1;
  localparam int LANE_CMD = 3;
  localparam int LANE_PORT = 2;

  // Access step codes of the nv access command field.
  localparam logic [2:0] CMD_LOAD_LO = 3'h4;
  localparam logic [2:0] CMD_LOAD_HI = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h6;
  localparam logic [2:0] CMD_READ = 3'h7;

  // External memory cycle time and its length in clock cycles, rounded up.
  localparam int CLK_PERIOD_NS = 40;
  localparam int NV_ACCESS_NS = 250;
  localparam int NV_ACCESS_CYCLES = (NV_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // One register access from the add-on register port.
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } reg_req_s;

  // Byte-wide nv memory pins driven by the device.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dataOut;
    logic dataOe;
    logic weN;
    logic oeN;
  } nv_pins_s;

endpackage : nv_access_pkg

/* design/nv_byte_port.sv */
// Byte-wide nv memory cycle engine: one timed read or write per start.
`timescale 1ns/10ps
module nv_byte_port #(
  parameter int ACCESS_CYCLES = nv_access_pkg::NV_ACCESS_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic start,
  input wire logic isRead,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic [7:0] nvDataIn,
  output nv_access_pkg::nv_pins_s nvPins,
  output logic done,
  output logic [7:0] rdByte
);
  import nv_access_pkg::*;

  typedef enum logic [1:0] {IDLE, ACCESS} eng_state_e;

  eng_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  nv_pins_s pins_q, pins_d;
  logic done_q, done_d;
  logic [7:0] rd_q, rd_d;
  logic readOp_q, readOp_d;

  // Drive the strobes for a fixed access time, then capture and report done.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pins_d = pins_q;
    done_d = 1'b0;
    rd_d = rd_q;
    readOp_d = readOp_q;
    unique case (state_q)
      IDLE:
      begin
        if (start)
        begin
          state_d = ACCESS;
          cnt_d = 8'(ACCESS_CYCLES - 1);
          readOp_d = isRead;
          pins_d.addr = memAddr;
          pins_d.dataOut = memWdata;
          pins_d.dataOe = !isRead;
          pins_d.weN = isRead;
          pins_d.oeN = !isRead;
        end
      end
      ACCESS:
      begin
        if (cnt_q == 8'h00)
        begin
          state_d = IDLE;
          done_d = 1'b1;
          pins_d.dataOe = 1'b0;
          pins_d.weN = 1'b1;
          pins_d.oeN = 1'b1;
          if (readOp_q)
          begin
            rd_d = nvDataIn;
          end
        end
        else
        begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
  end

  // Engine state registers.
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= IDLE;
      cnt_q <= 8'h00;
      pins_q <= '{addr: 16'h0000, dataOut: 8'h00, dataOe: 1'b0, weN: 1'b1, oeN: 1'b1};
      done_q <= 1'b0;
      rd_q <= 8'h00;
      readOp_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      done_q <= done_d;
      rd_q <= rd_d;
      readOp_q <= readOp_d;
    end
  end

  // Outputs come straight from the engine registers.
  assign nvPins = pins_q;
  assign done = done_q;
  assign rdByte = rd_q;

endmodule : nv_byte_port

/* verif/addon_nv_memory_access_control_tb_top.sv */
// Self-checking bench for the add-on control/status register and its nv port.
`timescale 1ns/10ps
module addon_nv_memory_access_control_tb_top;
  import nv_access_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic addonMasterMode = 1'b0;
  reg_req_s regReq = '0;
  logic [7:1] statusIn = 7'h7a;
  logic [7:0] nvDataIn;
  logic [31:0] regRdata;
  logic regRdValid;
  wire [2:0] pulse;
  wire countEnable;
  nv_pins_s nvPins;
  logic [63:0] expQ [$];
  logic [63:0] e;
  logic [31:0] lastRd = '0;
  logic [15:0] a;
  logic [7:0] d;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int pulses [3] = '{0, 0, 0};

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  addon_nv_memory_access_control #(.ACCESS_CYCLES(3)) dut (
    .mclk(mclk), .srst(srst), .addonMasterMode(addonMasterMode), .regReq(regReq),
    .statusIn(statusIn), .nvDataIn(nvDataIn), .regRdata(regRdata), .regRdValid(regRdValid),
    .mailboxFlagReset(pulse[2]), .outFifoFlagReset(pulse[1]), .inFifoFlagReset(pulse[0]),
    .transferCountEnable(countEnable), .nvPins(nvPins));

  nv_memory_model #(.READ_DELAY_NS(15)) u_mem (.mclk(mclk), .nvPins(nvPins), .nvDataIn(nvDataIn));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Watches answers against the oldest note, counts flag pulses and cuts a hang short.
  always @(posedge mclk)
  begin
    cycles++;
    for (int i = 0; i < 3; i++)
      pulses[i] += (pulse[i] === 1'b1);
    if (regRdValid === 1'b1)
    begin
      lastRd = regRdata;
      if (expQ.size() == 0)
        check("unexpected read answer", 32'h1, 32'h0);
      else
      begin
        e = expQ.pop_front();
        check("register read", regRdata & e[63:32], e[31:0]);
      end
    end
    if (cycles > 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // One request held for one edge, then one idle edge before the next.
  task automatic access(input logic wr, input logic [5:0] ad, input logic [31:0] wd,
                        input logic [3:0] be);
    regReq = '{sel: 1'b1, wr: wr, rd: ~wr, addr: ad, be: be, wdata: wd};
    @(posedge mclk);
    #1 regReq = '0;
    @(posedge mclk);
    #1;
  endtask : access

  task automatic readReg(input logic [31:0] mask, input logic [31:0] exp);
    expQ.push_back({mask, exp & mask});
    access(1'b0, AGCS_OFFSET, 32'h0, 4'hf);
  endtask : readReg

  task automatic step(input logic [2:0] code, input logic [7:0] port);
    access(1'b1, AGCS_OFFSET, {code, 5'h0, port, 16'h0}, 4'b1100);
  endtask : step

  // Reads until the busy bit clears, within a fixed number of reads.
  task automatic poll();
    int k;
    k = 0;
    do
    begin
      readReg(32'h0, 32'h0);
      k++;
    end
    while (lastRd[31] !== 1'b0 && k < 40);
    check("ready within bound", {31'h0, lastRd[31]}, 32'h0);
  endtask : poll

  // Main sequence: reset values, status, decode, flag pulses, nv write and read.
  initial
  begin
    void'($urandom(41));
    for (int m = 1; m >= 0; m--)
    begin
      srst = 1'b1;
      addonMasterMode = m[0];
      statusIn = m[0] ? 7'h1a : 7'h7a;
      repeat (5) @(posedge mclk);
      #1 srst = 1'b0;
      readReg(32'hffffffff, m[0] ? RESET_ADDON_MASTER : RESET_PCI_MASTER);
    end
    statusIn = 7'($urandom);
    repeat (2) @(posedge mclk);
    #1;
    readReg(32'h000000fe, {24'h0, statusIn, 1'b0});
    access(1'b0, 6'h38, 32'h0, 4'hf);
    access(1'b1, 6'h38, 32'h1e000000, 4'h8);
    check("count enable off", {31'h0, countEnable}, 32'h0);
    for (int i = 0; i < 3; i++)
      access(1'b1, AGCS_OFFSET, (32'h1 << (25 + i)) | 32'h10000000, 4'h8);
    readReg(32'h1f000000, 32'h10000000);
    check("count enable on", {31'h0, countEnable}, 32'h1);
    check("mailbox pulses", pulses[2], 1);
    check("outbound pulses", pulses[1], 1);
    check("inbound pulses", pulses[0], 1);
    for (int i = 0; i < 3; i++)
    begin
      a = 16'($urandom);
      d = 8'($urandom);
      step(CMD_LOAD_LO, a[7:0]);
      poll();
      step(CMD_LOAD_HI, a[15:8]);
      poll();
      step(CMD_WRITE, d);
      readReg(32'he0000000, 32'hc0000000);
      step(CMD_LOAD_LO, ~a[7:0]);
      poll();
      check("stored byte", {24'h0, u_mem.mem[int'(a)]}, {24'h0, d});
      step(3'h3, ~d);
      step(CMD_READ, 8'h00);
      poll();
      readReg(32'h80ff0000, {8'h0, d, 16'h0});
    end
    check("answers outstanding", expQ.size(), 32'h0);
    report_and_stop();
  end
endmodule : addon_nv_memory_access_control_tb_top

/* verif/nv_memory_model.sv */
// Behavioural byte-wide nv memory that answers the device's strobes.
`timescale 1ns/10ps
module nv_memory_model #(
  parameter int READ_DELAY_NS = 0
) (
  input wire logic mclk,
  input nv_access_pkg::nv_pins_s nvPins,
  output logic [7:0] nvDataIn
);
  import nv_access_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] lastQ = 8'h00;
  logic [7:0] drive;
  // Store the byte while the write strobe is low and remember the last byte driven.
  always @(posedge mclk)
  begin
    if (!nvPins.weN && nvPins.dataOe)
    begin
      mem[nvPins.addr] = nvPins.dataOut;
    end
    if (!nvPins.oeN)
    begin
      lastQ = drive;
    end
  end
  // A floating bus shows the inverse of the last byte so a stale sample is caught.
  always @*
  begin
    drive = (!nvPins.oeN && mem.exists(nvPins.addr)) ? mem[nvPins.addr] : ~lastQ;
  end
  assign #(READ_DELAY_NS) nvDataIn = drive;
endmodule : nv_memory_model
